/* File: rtl/plc_input_command_decoder.sv */
`timescale 1ns/100ps
`default_nettype none

// Operation
// - inputs honoured only under controller control location
// - each contact assignable, factory default per contact
// - every function selectable with inverted polarity
// - offset null on rise, off on fall
// - start/stop: start on rise, stop on fall
// - start function acts on rising edge only
// - stop on rise; flood after hold delay
// - inlet flood on rising edge
// - purge flushing on at rise, off at fall
// - clear acknowledges error or aborts adjustment
// - adjust request: internal in standby, external in measure, else nothing
// - internal adjust trigger always starts internal routine
// - external adjust trigger starts external routine
// - run toggle starts in standby, else stops
// - purge valve open on rising edge
// - purge valve close on rising edge
// - null set enables; standby entry clears it
// - probe mode entered/left only while in standby
module plc_input_command_decoder
    import plc_cmd_pkg::*;
#(
    parameter int N         = plc_cmd_pkg::NUM_INPUTS,
    parameter int MS_CYCLES = plc_cmd_pkg::CYCLES_PER_MS
) (
    // clock and reset
    input  wire logic                           core_clk,
    input  wire logic                           sys_rst,
    // controller contacts, asynchronous
    input  wire logic [N-1:0]                   plc_in,
    // configuration
    input  wire plc_cmd_pkg::ctrl_loc_type      ctrl_loc,
    input  wire logic [plc_cmd_pkg::DELAY_W-1:0] flood_hold_delay,
    input  wire logic                           map_wr,
    input  wire logic [plc_cmd_pkg::IDX_W-1:0]  map_idx,
    input  wire plc_cmd_pkg::func_type          map_func,
    input  wire logic                           map_inv,
    // instrument state, same clock
    input  wire logic                           in_standby,
    input  wire logic                           in_measure,
    input  wire logic                           ext_adjust_busy,
    // command pulses to the sequencer
    output logic                                start_cmd,
    output logic                                stop_cmd,
    output logic                                flood_cmd,
    output logic                                clear_cmd,
    output logic                                int_adjust_cmd,
    output logic                                ext_adjust_cmd,
    output logic                                adjust_confirm_cmd,
    output logic                                probe_on_cmd,
    output logic                                probe_off_cmd,
    // levels
    output logic                                null_active,
    output logic                                purge_active,
    output logic                                accepted
);
    import plc_cmd_pkg::*;

    localparam int PRE_W = $clog2(MS_CYCLES);

    // ------------------------------------------------------------
    // contact assignment table
    // ------------------------------------------------------------
    func_type         func_map [N];
    logic [N-1:0]     inv_map;
    logic [N-1:0]     lvl;
    logic [N-1:0]     rise;
    logic [N-1:0]     fall;
    logic [15:0]      rise_f;
    logic [15:0]      fall_f;
    logic [15:0]      lvl_f;
    logic             accept;
    logic             stby_prev;
    logic             stby_rise;
    logic             stop_hold;
    logic [PRE_W-1:0] pre_cnt;
    logic [DELAY_W-1:0] ms_cnt;
    logic             hold_fired;
    logic             ms_tick;
    logic             hold_fire;

    // per-contact function and polarity, factory default at reset
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < N; i++) begin
                func_map[i] <= DEFAULT_FUNC[i];
            end
            inv_map <= DEFAULT_INV;
        end else if (map_wr) begin
            func_map[map_idx] <= map_func;
            inv_map[map_idx]  <= map_inv;
        end
    end

    // ------------------------------------------------------------
    // conditioning and decode
    // ------------------------------------------------------------
    input_conditioner #(
        .WIDTH (N)
    ) u_cond (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .raw_in   (plc_in),
        .invert   (inv_map),
        .level    (lvl),
        .rise     (rise),
        .fall     (fall)
    );

    // gather edges and levels by assigned function
    always_comb begin
        rise_f = '0;
        fall_f = '0;
        lvl_f  = '0;
        for (int i = 0; i < N; i++) begin
            rise_f[func_map[i]] = rise_f[func_map[i]] | rise[i];
            fall_f[func_map[i]] = fall_f[func_map[i]] | fall[i];
            lvl_f[func_map[i]]  = lvl_f[func_map[i]] | lvl[i];
        end
    end

    assign accept = (ctrl_loc == loc_plc) || (ctrl_loc == loc_local_plc)
                    || (ctrl_loc == loc_all);

    // standby entry detect, state is already on this clock
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stby_prev <= 1'b0;
        end else begin
            stby_prev <= in_standby;
        end
    end
    assign stby_rise = in_standby & ~stby_prev;

    // ------------------------------------------------------------
    // stop hold timer
    // ------------------------------------------------------------
    // flood once after stop held past the delay
    // restart on any release so a short pulse never floods
    assign stop_hold = accept & lvl_f[fn_stop];
    assign ms_tick   = (pre_cnt == PRE_W'(MS_CYCLES - 1));
    assign hold_fire = stop_hold & ms_tick & ~hold_fired & (ms_cnt == flood_hold_delay);

    always_ff @(posedge core_clk) begin
        if (sys_rst || !stop_hold) begin
            pre_cnt    <= '0;
            ms_cnt     <= '0;
            hold_fired <= 1'b0;
        end else if (ms_tick) begin
            pre_cnt <= '0;
            if (hold_fire) begin
                hold_fired <= 1'b1;
            end else if (ms_cnt != '1) begin
                ms_cnt <= ms_cnt + 1'b1;
            end
        end else begin
            pre_cnt <= pre_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // command pulses
    // ------------------------------------------------------------
    // registered one-cycle pulses, gated by location
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            start_cmd          <= 1'b0;
            stop_cmd           <= 1'b0;
            flood_cmd          <= 1'b0;
            clear_cmd          <= 1'b0;
            int_adjust_cmd     <= 1'b0;
            ext_adjust_cmd     <= 1'b0;
            adjust_confirm_cmd <= 1'b0;
            probe_on_cmd       <= 1'b0;
            probe_off_cmd      <= 1'b0;
        end else begin
            start_cmd <= accept & (rise_f[fn_start] | rise_f[fn_start_stop]
                         | (rise_f[fn_run_toggle] & in_standby));
            stop_cmd <= accept & (rise_f[fn_stop] | fall_f[fn_start_stop]
                        | (rise_f[fn_run_toggle] & ~in_standby));
            // flood on edge or hold expiry
            flood_cmd <= (accept & rise_f[fn_inlet_flood]) | hold_fire;
            clear_cmd <= accept & rise_f[fn_clear];
            int_adjust_cmd <= accept & (rise_f[fn_internal_adjust]
                              | (rise_f[fn_adjust_request] & in_standby));
            ext_adjust_cmd <= accept & (rise_f[fn_external_adjust]
                              | (rise_f[fn_adjust_request] & in_measure & ~in_standby));
            adjust_confirm_cmd <= accept & fall_f[fn_adjust_request] & ext_adjust_busy;
            // probe mode changes only in standby
            probe_on_cmd  <= accept & rise_f[fn_probe_mode] & in_standby;
            probe_off_cmd <= accept & fall_f[fn_probe_mode] & in_standby;
        end
    end

    // ------------------------------------------------------------
    // level functions
    // ------------------------------------------------------------
    // nulling state, a set beats a clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            null_active <= 1'b0;
        end else if (accept & (rise_f[fn_offset_null] | rise_f[fn_offset_null_set])) begin
            null_active <= 1'b1;
        end else if ((accept & fall_f[fn_offset_null]) | stby_rise) begin
            null_active <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            purge_active <= 1'b0;
        end else if (accept & (rise_f[fn_purge_control] | rise_f[fn_purge_open])) begin
            purge_active <= 1'b1;
        end else if (accept & (fall_f[fn_purge_control] | rise_f[fn_purge_close])) begin
            purge_active <= 1'b0;
        end
    end

    // status of the gate for the host
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            accepted <= 1'b0;
        end else begin
            accepted <= accept;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_gate_blocks_cmds: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !accept |=> !(start_cmd || stop_cmd || flood_cmd || clear_cmd || int_adjust_cmd || ext_adjust_cmd
                      || adjust_confirm_cmd || probe_on_cmd || probe_off_cmd))
        else $error("command issued while location refuses inputs");

    a_null_on_fall: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        accept && fall_f[fn_offset_null] && !rise_f[fn_offset_null_set] && !rise_f[fn_offset_null]
        |=> !null_active)
        else $error("nulling not cleared on falling edge");

    a_start_on_rise: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        accept && rise_f[fn_start] |=> start_cmd ##1 (!start_cmd || $past(accept && (rise_f[fn_start]
            || rise_f[fn_start_stop] || (rise_f[fn_run_toggle] && in_standby)))))
        else $error("start edge did not give a start pulse");

    a_flood_hold: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        hold_fire |=> flood_cmd && hold_fired)
        else $error("stop hold expiry did not flood");

    a_purge_on_rise: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        accept && rise_f[fn_purge_control] |=> purge_active)
        else $error("purge flushing not switched on");

    a_adjust_route: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        accept && rise_f[fn_adjust_request] && !in_standby && in_measure
        |=> ext_adjust_cmd && !int_adjust_cmd || $past(rise_f[fn_internal_adjust]))
        else $error("adjust request in measure not routed external");

    a_toggle_split: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        accept && rise_f[fn_run_toggle] |=> (start_cmd == $past(in_standby))
            || $past(rise_f[fn_start] || rise_f[fn_start_stop]))
        else $error("run toggle chose wrong action");

    a_standby_clears: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        stby_rise && !(accept && (rise_f[fn_offset_null] || rise_f[fn_offset_null_set]))
        |=> !null_active)
        else $error("standby entry kept nulling on");

    a_probe_standby: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (probe_on_cmd || probe_off_cmd) |-> $past(in_standby))
        else $error("probe mode change outside standby");

    a_flood_on_edge: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        accept && rise_f[fn_inlet_flood] |=> flood_cmd)
        else $error("flood edge did not give a flood pulse");

    a_clear_on_rise: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        accept && rise_f[fn_clear] |=> clear_cmd)
        else $error("clear edge did not give a clear pulse");

    a_confirm_on_fall: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        accept && fall_f[fn_adjust_request] && ext_adjust_busy |=> adjust_confirm_cmd)
        else $error("dropped request did not confirm adjustment");

    a_ext_trigger_route: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        accept && rise_f[fn_external_adjust] |=> ext_adjust_cmd)
        else $error("external trigger did not start external adjustment");

    a_purge_close_rise: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        accept && rise_f[fn_purge_close] && !rise_f[fn_purge_open] && !rise_f[fn_purge_control]
        |=> !purge_active)
        else $error("purge valve not closed on close edge");

endmodule

`default_nettype wire

/* File: rtl/plc_cmd_pkg.sv */
// ----------------------------------------------------------------
// shared constants and types of the controller input decoder
// ----------------------------------------------------------------
package plc_cmd_pkg;

    // number of configurable contacts and field widths
    localparam int NUM_INPUTS    = 8;
    localparam int IDX_W         = 3;
    localparam int DELAY_W       = 16;

    // timing: flood hold delay is counted in whole milliseconds
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS         = 1000000;
    localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

    // functions a contact may be assigned to
    typedef enum logic [3:0] {
        fn_none,
        fn_offset_null,
        fn_start_stop,
        fn_start,
        fn_stop,
        fn_inlet_flood,
        fn_purge_control,
        fn_clear,
        fn_adjust_request,
        fn_internal_adjust,
        fn_external_adjust,
        fn_run_toggle,
        fn_purge_open,
        fn_purge_close,
        fn_offset_null_set,
        fn_probe_mode
    } func_type;

    // control location setting
    typedef enum logic [1:0] {
        loc_local,
        loc_plc,
        loc_local_plc,
        loc_all
    } ctrl_loc_type;

    // factory assignment of contacts 0..7 after reset
    localparam func_type DEFAULT_FUNC [NUM_INPUTS] = '{
        fn_start, fn_stop, fn_offset_null, fn_adjust_request,
        fn_internal_adjust, fn_external_adjust, fn_clear, fn_purge_control
    };
    localparam logic [NUM_INPUTS-1:0] DEFAULT_INV = 8'h00;

endpackage

/* File: rtl/input_conditioner.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// synchroniser, polarity swap and edge detect for the contacts
// ----------------------------------------------------------------
module input_conditioner #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // raw contacts and polarity
    input  wire logic [WIDTH-1:0] raw_in,
    input  wire logic [WIDTH-1:0] invert,
    // conditioned level and edges
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            meta <= '0;
            sync <= '0;
        end else begin
            meta <= raw_in;
            sync <= meta;
        end
    end

    // polarity swap before edge detect
    // a change of polarity while the contact is steady looks like an edge
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            level <= '0;
            prev  <= '0;
        end else begin
            level <= sync ^ invert;
            prev  <= level;
        end
    end

    // edges from current versus previous sample
    assign rise = level & ~prev;
    assign fall = ~level & prev;

endmodule

`default_nettype wire

/* File: dv/plc_contact_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// controller contact model
// ----------------------------------------------------------------
module plc_contact_model (
    // clock of the sampling side
    input  wire logic                                core_clk,
    // contact levels toward the decoder
    output var logic [plc_cmd_pkg::NUM_INPUTS-1:0] plc_in
);
    import plc_cmd_pkg::*;

    // contacts start open, so every level is low
    initial plc_in = 8'h00;

    // a contact changes just after an edge, like a scan-cycle output
    task automatic drive(input int idx, input logic val);
        @(posedge core_clk);
        #1;
        plc_in[idx] = val;
    endtask

    // external adjust confirmation
    // request dropped only after settle_cycles+1 clock edges have passed
    task automatic confirm_adjust(input int idx, input int settle_cycles);
        repeat (settle_cycles) @(posedge core_clk);
        drive(idx, 1'b0);
    endtask
endmodule

`default_nettype wire

/* File: dv/plc_input_command_decoder_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module plc_input_command_decoder_tb_top;
    import plc_cmd_pkg::*;

    // ----------------------------------------------------------------
    // constants and signals
    // ----------------------------------------------------------------
    // short millisecond keeps the hold-delay test brief
    localparam int MS_T = 4;
    // pulse order: start stop flood clear int ext confirm probe_on probe_off
    localparam logic [8:0] P_START = 9'h100;
    localparam logic [8:0] P_STOP  = 9'h080;
    localparam logic [8:0] P_FLOOD = 9'h040;
    localparam logic [8:0] P_CLEAR = 9'h020;
    localparam logic [8:0] P_INT   = 9'h010;
    localparam logic [8:0] P_EXT   = 9'h008;
    localparam logic [8:0] P_CONF  = 9'h004;
    localparam logic [8:0] P_PON   = 9'h002;
    localparam logic [8:0] P_POFF  = 9'h001;
    // factory map: pulse on rise and {null,purge} level after rise
    localparam logic [8:0] DEF_RISE [8] = '{P_START, P_STOP, 9'h000, P_INT, P_INT, P_EXT, P_CLEAR, 9'h000};
    localparam logic [8:0] DEF_LVL  [8] = '{9'h000, 9'h000, 9'h002, 9'h000, 9'h000, 9'h000, 9'h000, 9'h001};

    logic                        core_clk;
    logic                        sys_rst;
    wire logic [NUM_INPUTS-1:0]  plc_in;
    ctrl_loc_type                ctrl_loc;
    logic [DELAY_W-1:0]          flood_hold_delay;
    logic                        map_wr;
    logic [IDX_W-1:0]            map_idx;
    func_type                    map_func;
    logic                        map_inv;
    logic                        in_standby;
    logic                        in_measure;
    logic                        ext_adjust_busy;
    logic                        start_cmd;
    logic                        stop_cmd;
    logic                        flood_cmd;
    logic                        clear_cmd;
    logic                        int_adjust_cmd;
    logic                        ext_adjust_cmd;
    logic                        adjust_confirm_cmd;
    logic                        probe_on_cmd;
    logic                        probe_off_cmd;
    logic                        null_active;
    logic                        purge_active;
    logic                        accepted;
    logic [8:0]                  pulses;
    int                          miscompares;
    int                          total_checks;

    // all command pulses gathered for window checks
    assign pulses = {start_cmd, stop_cmd, flood_cmd, clear_cmd, int_adjust_cmd,
                     ext_adjust_cmd, adjust_confirm_cmd, probe_on_cmd, probe_off_cmd};

    // ----------------------------------------------------------------
    // design and contact model
    // ----------------------------------------------------------------
    plc_input_command_decoder #(.MS_CYCLES(MS_T)) uut (
        .core_clk(core_clk), .sys_rst(sys_rst), .plc_in(plc_in), .ctrl_loc(ctrl_loc),
        .flood_hold_delay(flood_hold_delay), .map_wr(map_wr), .map_idx(map_idx),
        .map_func(map_func), .map_inv(map_inv), .in_standby(in_standby),
        .in_measure(in_measure), .ext_adjust_busy(ext_adjust_busy), .start_cmd(start_cmd),
        .stop_cmd(stop_cmd), .flood_cmd(flood_cmd), .clear_cmd(clear_cmd),
        .int_adjust_cmd(int_adjust_cmd), .ext_adjust_cmd(ext_adjust_cmd),
        .adjust_confirm_cmd(adjust_confirm_cmd), .probe_on_cmd(probe_on_cmd),
        .probe_off_cmd(probe_off_cmd), .null_active(null_active),
        .purge_active(purge_active), .accepted(accepted)
    );

    plc_contact_model plc (
        .core_clk(core_clk),
        .plc_in  (plc_in)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // gather pulses over n cycles; a held level must not repeat a command
    task automatic watch(input int n, input logic [8:0] exp, input string what);
        logic [8:0] seen;
        logic [8:0] twice;
        seen = 9'h000;
        twice = 9'h000;
        repeat (n) begin
            @(posedge core_clk);
            #1;
            twice = twice | (seen & pulses);
            seen = seen | pulses;
        end
        check({what, " pulses"}, seen, exp);
        check({what, " repeats"}, twice, 9'h000);
    endtask

    task automatic act(input int idx, input logic val, input int n, input logic [8:0] exp, input string what);
        plc.drive(idx, val);
        watch(n, exp, what);
    endtask

    task automatic levels(input logic [8:0] exp, input string what);
        check(what, {7'h00, null_active, purge_active}, exp);
    endtask

    task automatic set_state(input logic sb, input logic ms, input logic busy);
        @(posedge core_clk);
        #1;
        in_standby = sb;
        in_measure = ms;
        ext_adjust_busy = busy;
    endtask

    task automatic set_map(input int idx, input func_type fn, input logic inv);
        @(posedge core_clk);
        #1;
        map_wr = 1'b1;
        map_idx = idx[IDX_W-1:0];
        map_func = fn;
        map_inv = inv;
        @(posedge core_clk);
        #1;
        map_wr = 1'b0;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        check("reset pulses", pulses, 9'h000);
        levels(9'h000, "reset levels");
        check("accepted", {8'h00, accepted}, 9'h001);
    endtask

    // factory functions of every contact, rise then fall
    task automatic t_defaults();
        for (int i = 0; i < 8; i++) begin
            act(i, 1'b1, 8, DEF_RISE[i], "default rise");
            levels(DEF_LVL[i], "default level on");
            act(i, 1'b0, 8, 9'h000, "default fall");
            levels(9'h000, "default level off");
        end
    endtask

    task automatic t_location();
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk);
            #1;
            ctrl_loc = ctrl_loc_type'(k);
            repeat (2) @(posedge core_clk);
            #1;
            check("location gate", {8'h00, accepted}, {8'h00, k != 0});
            act(0, 1'b1, 8, (k == 0) ? 9'h000 : P_START, "location start");
            act(0, 1'b0, 8, 9'h000, "location release");
        end
    endtask

    // stop held past the delay floods once, at (delay+1) ms
    task automatic t_flood();
        act(1, 1'b1, 8, P_STOP, "stop hold");
        watch(12, P_FLOOD, "hold flood");
        watch(8, 9'h000, "hold after flood");
        act(1, 1'b0, 8, 9'h000, "stop release");
    endtask

    task automatic t_adjust();
        set_state(1'b0, 1'b1, 1'b0);
        act(3, 1'b1, 8, P_EXT, "request in measure");
        set_state(1'b0, 1'b1, 1'b1);
        plc.confirm_adjust(3, 2);
        watch(8, P_CONF, "confirm");
        set_state(1'b1, 1'b0, 1'b0);
    endtask

    task automatic t_remap();
        set_map(0, fn_start_stop, 1'b0);
        act(0, 1'b1, 8, P_START, "start_stop rise");
        act(0, 1'b0, 8, P_STOP, "start_stop fall");
        set_map(0, fn_inlet_flood, 1'b0);
        act(0, 1'b1, 8, P_FLOOD, "flood rise");
        act(0, 1'b0, 8, 9'h000, "flood fall");
        set_map(0, fn_run_toggle, 1'b0);
        act(0, 1'b1, 8, P_START, "toggle standby");
        act(0, 1'b0, 8, 9'h000, "toggle fall");
        set_state(1'b0, 1'b1, 1'b0);
        act(0, 1'b1, 8, P_STOP, "toggle running");
        act(0, 1'b0, 8, 9'h000, "toggle fall");
        set_map(0, fn_purge_open, 1'b0);
        act(0, 1'b1, 8, 9'h000, "purge open");
        levels(9'h001, "purge opened");
        act(0, 1'b0, 8, 9'h000, "purge open fall");
        set_map(0, fn_purge_close, 1'b0);
        act(0, 1'b1, 8, 9'h000, "purge close");
        levels(9'h000, "purge closed");
        act(0, 1'b0, 8, 9'h000, "purge close fall");
        set_map(0, fn_offset_null_set, 1'b0);
        act(0, 1'b1, 8, 9'h000, "null set");
        act(0, 1'b0, 8, 9'h000, "null set fall");
        levels(9'h002, "null held");
        set_state(1'b1, 1'b0, 1'b0);
        repeat (3) @(posedge core_clk);
        #1;
        levels(9'h000, "null cleared by standby");
        set_map(0, fn_probe_mode, 1'b0);
        act(0, 1'b1, 8, P_PON, "probe on");
        act(0, 1'b0, 8, P_POFF, "probe off");
        set_state(1'b0, 1'b1, 1'b0);
        act(0, 1'b1, 8, 9'h000, "probe running");
        act(0, 1'b0, 8, 9'h000, "probe running off");
        set_state(1'b1, 1'b0, 1'b0);
    endtask

    // inverting a steady low contact is itself a rising edge
    task automatic t_invert();
        set_map(0, fn_start, 1'b1);
        watch(8, P_START, "invert edge");
        act(0, 1'b1, 8, 9'h000, "inverted high");
        act(0, 1'b0, 8, P_START, "inverted low");
        set_map(0, fn_start, 1'b0);
        watch(8, 9'h000, "invert undone");
    endtask

    // ----------------------------------------------------------------
    // clock, sequence and verdict
    // ----------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    initial begin
        sys_rst = 1'b1;
        ctrl_loc = loc_plc;
        flood_hold_delay = 16'h0002;
        map_wr = 1'b0;
        map_idx = 3'h0;
        map_func = fn_none;
        map_inv = 1'b0;
        in_standby = 1'b1;
        in_measure = 1'b0;
        ext_adjust_busy = 1'b0;
        miscompares = 0;
        total_checks = 0;
        repeat (8) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        t_reset();
        t_defaults();
        t_location();
        t_flood();
        t_adjust();
        t_remap();
        t_invert();
        final_report();
    end

    // scenarios need about 520 cycles; a hang is cut well beyond that
    initial begin
        repeat (6000) @(posedge core_clk);
        miscompares++;
        final_report();
    end
endmodule

`default_nettype wire
